// *** rtl/ecer_pkg.sv ***
// package: exception cause / return pc register constants and types
package ecer_pkg;
    localparam int CAUSE_CHAIN_BIT   = 25;
    localparam int CAUSE_APRO_BIT    = 24;
    localparam int CAUSE_IVSEL_BIT   = 23;
    localparam int CAUSE_DEBUG_CHANNEL_IRQ_PENDING_BIT    = 21;
    localparam int CAUSE_HWP_LO      = 10;
    localparam int CAUSE_SWI_LO      = 8;
    localparam int CAUSE_CODE_LO     = 2;
    localparam int VIEW_HWP_LO       = 2;
    localparam int SNAP_ERL_BIT      = 2;
    localparam int SNAP_EXL_BIT      = 1;

    localparam logic [31:0] VEC_GENERAL = 32'h0000_0180;
    localparam logic [31:0] VEC_SPECIAL = 32'h0000_0200;

    // register selectors on the coprocessor move port
    localparam logic [1:0] SEL_CAUSE = 2'h0;
    localparam logic [1:0] SEL_VIEW  = 2'h1;
    localparam logic [1:0] SEL_SNAP  = 2'h2;
    localparam logic [1:0] SEL_EPC   = 2'h3;

    localparam logic [4:0] EXC_INT   = 5'h00;
    localparam logic [4:0] EXC_ADEL  = 5'h04;
    localparam logic [4:0] EXC_ADES  = 5'h05;
    localparam logic [4:0] EXC_IBE   = 5'h06;
    localparam logic [4:0] EXC_DBE   = 5'h07;
    localparam logic [4:0] EXC_SYS   = 5'h08;
    localparam logic [4:0] EXC_BP    = 5'h09;
    localparam logic [4:0] EXC_RI    = 5'h0a;
    localparam logic [4:0] EXC_CPU   = 5'h0b;
    localparam logic [4:0] EXC_OV    = 5'h0c;
    localparam logic [4:0] EXC_TR    = 5'h0d;
    localparam logic [4:0] EXC_IS1   = 5'h10;
    localparam logic [4:0] EXC_CEU   = 5'h11;
    localparam logic [4:0] EXC_C2E   = 5'h12;
    localparam logic [4:0] EXC_DSPD  = 5'h1a;
    localparam logic [4:0] EXC_PROT  = 5'h1d;
    localparam logic [4:0] EXC_SRAM  = 5'h1e;

    // kind of exception being accepted this cycle
    typedef enum logic [2:0] {
        ECER_KIND_NORMAL = 3'h0,
        ECER_KIND_ERROR  = 3'h1,
        ECER_KIND_SRAM   = 3'h2,
        ECER_KIND_DEBUG  = 3'h3
    } ecer_kind_t;

    typedef struct packed {
        logic        take;
        ecer_kind_t  kind;
        logic [4:0]  code;
        logic [31:0] pc;
        logic [31:0] branch_pc;
        logic        in_slot;
        logic        in_prologue;
    } ecer_exc_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [1:0]  sel;
        logic [31:0] wdata;
    } ecer_cop_t;

    function automatic logic ecer_code_legal(input logic [4:0] c);
        case (c)
            EXC_INT, EXC_ADEL, EXC_ADES, EXC_IBE, EXC_DBE, EXC_SYS,
            EXC_BP, EXC_RI, EXC_CPU, EXC_OV, EXC_TR, EXC_IS1, EXC_CEU,
            EXC_C2E, EXC_DSPD, EXC_PROT: ecer_code_legal = 1'b1;
            default: ecer_code_legal = 1'b0;
        endcase
    endfunction : ecer_code_legal
endpackage : ecer_pkg

// *** rtl/ecer_regs.sv ***
// exception cause, pending view, prior level snapshot and return pc
`timescale 1ns/1ps
// Contract
// - bit 25 read-only, 1 when chaining happened on last interrupt return.
// - bit 24 read-only, set when exception taken during auto prologue.
// - bit 23 writable; 0 selects vector 0x180, 1 selects 0x200.
// - with bit 23 set and boot vector off, 0x200 is vectored base.
// - bit 21 shows debug-channel interrupt pending, resets to 0.
// - bits 17:10 show hw interrupts 7..0; all eight reset to 0.
// - timer and perf-counter interrupts merged into one hw input.
// - external controller mode: bits 17:10 show requested level 0..255.
// - bits 9:8 writable software interrupt requests 1 and 0.
// - software request bits driven on two-bit output bus.
// - five-bit exception code at bits 6:2 records latest cause.
// - codes 0 and 4 through 13 encode the basic exceptions.
// - codes 16,17,18,26,29 encode extension exceptions; others reserved.
// - sram error leaves cause alone; in debug gives code 30 on output.
// - bits 22, 20:18, 7, 1:0 read as zero.
// - view register: level in 9:2 read-only, soft bits 1:0 writable.
// - snapshot keeps prior error level bit 2, exception level bit 1.
// - saved error level updated by non-debug level-setting exceptions.
// - saved exception level updated by return-pc kinds only.
// - return pc gets faulting pc, or branch pc with slot flag.
// - return pc read gives pc 31:1 and isa mode bit 0.
// - return pc write stores 31:1, clears bit 0, isa mode = {0,d0}.
module ecer_regs
    import ecer_pkg::*;
#(
    parameter int HW_IRQS   = 8,
    parameter int MERGE_IDX = 5
) (
    input  wire logic                MCLK,
    input  wire logic                RST,
    input  wire ecer_exc_t           EXC,
    input  wire ecer_cop_t           COP,
    input  wire logic                INTERRUPT_RETURN_INSTR_DONE,
    input  wire logic                INTERRUPT_RETURN_INSTR_CHAINED,
    input  wire logic                EIC_MODE,
    input  wire logic [HW_IRQS-1:0]  HW_IRQ,
    input  wire logic                TIMER_IRQ,
    input  wire logic                PERF_IRQ,
    input  wire logic                FDC_IRQ,
    input  wire logic [7:0]          EIC_LEVEL,
    input  wire logic                BOOT_VEC,
    input  wire logic                STATUS_EXL,
    input  wire logic                STATUS_ERL,
    input  wire logic                DEBUG_MODE,
    output logic [31:0]              RDATA,
    output logic [1:0]               SOFT_IRQ_OUT,
    output logic [31:0]              VECTOR_OFFSET,
    output logic                     VECTORED_BASE,
    output logic [31:0]              CAUSE_OUT,
    output logic                     BRANCH_SLOT,
    output logic [1:0]               ISA_MODE,
    output logic                     DEBUG_SRAM_CODE_VALID,
    output logic [4:0]               DEBUG_SRAM_CODE
);
    logic        chained_return_flag;
    logic        autoprologue_exception_flag;
    logic        interrupt_vector_select;
    logic        debug_channel_irq_pending;
    logic [7:0]  hw_pending_bits;
    logic [1:0]  soft_irq_request_bits;
    logic [4:0]  exception_cause_code;
    logic        snap_erl;
    logic        snap_exl;
    logic [31:0] exception_return_pc;
    logic [HW_IRQS-1:0] merged_irq;
    logic [7:0]  next_pending;
    logic [31:0] cause_word;
    logic [31:0] next_rdata;
    logic        normal_take;
    logic        cop_wr_cause;

    assign normal_take  = EXC.take && EXC.kind == ECER_KIND_NORMAL;
    assign cop_wr_cause = COP.wr && (COP.sel == SEL_CAUSE);

    always_comb begin
        merged_irq = HW_IRQ;
        merged_irq[MERGE_IDX] = HW_IRQ[MERGE_IDX] | TIMER_IRQ
                              | PERF_IRQ;
    end

    always_comb begin
        if (EIC_MODE) begin
            next_pending = EIC_LEVEL;
        end else begin
            next_pending = merged_irq[7:0];
        end
    end

    // pending and debug channel inputs are sampled every cycle
    always_ff @(posedge MCLK) begin
        if (RST) begin
            hw_pending_bits           <= 8'h00;
            debug_channel_irq_pending <= 1'b0;
        end else begin
            hw_pending_bits           <= next_pending;
            debug_channel_irq_pending <= FDC_IRQ;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            chained_return_flag <= 1'b0;
        end else if (INTERRUPT_RETURN_INSTR_DONE) begin
            chained_return_flag <= INTERRUPT_RETURN_INSTR_CHAINED;
        end
    end

    // cause fields update with a normal redirect of legal code; error, sram and debug leave them alone
    always_ff @(posedge MCLK) begin
        if (RST) begin
            autoprologue_exception_flag <= 1'b0;
            exception_cause_code        <= EXC_INT;
            BRANCH_SLOT                 <= 1'b0;
        end else if (normal_take && ecer_code_legal(EXC.code)) begin
            autoprologue_exception_flag <= EXC.in_prologue;
            exception_cause_code <= EXC.code;
            if (!STATUS_EXL) begin
                BRANCH_SLOT <= EXC.in_slot;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            interrupt_vector_select <= 1'b0;
        end else if (cop_wr_cause) begin
            interrupt_vector_select <= COP.wdata[CAUSE_IVSEL_BIT];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            soft_irq_request_bits <= 2'h0;
        end else if (cop_wr_cause) begin
            soft_irq_request_bits <= COP.wdata[CAUSE_SWI_LO +: 2];
        end else if (COP.wr && COP.sel == SEL_VIEW) begin
            soft_irq_request_bits <= COP.wdata[1:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            snap_erl <= 1'b0;
            snap_exl <= 1'b0;
        end else if (EXC.take && EXC.kind != ECER_KIND_DEBUG) begin
            snap_erl <= STATUS_ERL;
            if (EXC.kind == ECER_KIND_NORMAL) begin
                snap_exl <= STATUS_EXL;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            exception_return_pc      <= 32'h0000_0000;
            ISA_MODE <= 2'h0;
        end else if (COP.wr && COP.sel == SEL_EPC) begin
            exception_return_pc      <= {COP.wdata[31:1], 1'b0};
            ISA_MODE <= {1'b0, COP.wdata[0]};
        end else if (normal_take && !STATUS_EXL) begin
            exception_return_pc <= EXC.in_slot ? EXC.branch_pc : EXC.pc;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            DEBUG_SRAM_CODE_VALID <= 1'b0;
            DEBUG_SRAM_CODE       <= 5'h00;
        end else begin
            DEBUG_SRAM_CODE_VALID <= EXC.take && EXC.kind == ECER_KIND_SRAM
                                     && DEBUG_MODE;
            DEBUG_SRAM_CODE <= EXC_SRAM;
        end
    end

    always_comb begin
        cause_word = 32'h0000_0000;
        cause_word[CAUSE_CHAIN_BIT] = chained_return_flag;
        cause_word[CAUSE_APRO_BIT]  = autoprologue_exception_flag;
        cause_word[CAUSE_IVSEL_BIT] = interrupt_vector_select;
        cause_word[CAUSE_DEBUG_CHANNEL_IRQ_PENDING_BIT]  = debug_channel_irq_pending;
        cause_word[CAUSE_HWP_LO +: 8]  = hw_pending_bits;
        cause_word[CAUSE_SWI_LO +: 2]  = soft_irq_request_bits;
        cause_word[CAUSE_CODE_LO +: 5] = exception_cause_code;
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (COP.sel)
            SEL_CAUSE: next_rdata = cause_word;
            SEL_VIEW: begin
                next_rdata[VIEW_HWP_LO +: 8] = hw_pending_bits;
                next_rdata[1:0] = soft_irq_request_bits;
            end
            SEL_SNAP: begin
                next_rdata[SNAP_ERL_BIT] = snap_erl;
                next_rdata[SNAP_EXL_BIT] = snap_exl;
            end
            SEL_EPC: next_rdata = {exception_return_pc[31:1], ISA_MODE[0]};
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            RDATA <= 32'h0000_0000;
        end else if (COP.rd) begin
            RDATA <= next_rdata;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            SOFT_IRQ_OUT  <= 2'h0;
            VECTOR_OFFSET <= VEC_GENERAL;
            VECTORED_BASE <= 1'b0;
            CAUSE_OUT     <= 32'h0000_0000;
        end else begin
            SOFT_IRQ_OUT  <= soft_irq_request_bits;
            VECTOR_OFFSET <= interrupt_vector_select ? VEC_SPECIAL
                                                     : VEC_GENERAL;
            VECTORED_BASE <= interrupt_vector_select && !BOOT_VEC;
            CAUSE_OUT     <= cause_word;
        end
    end

    a_code_legal: assert property (
        @(posedge MCLK) disable iff (RST)
        ecer_code_legal(exception_cause_code))
        else $error("reserved exception code held");

    a_code_keep: assert property (
        @(posedge MCLK) disable iff (RST)
        (EXC.take && !ecer_code_legal(EXC.code)) |=>
        $stable(exception_cause_code))
        else $error("reserved code reached the cause field");

    a_code_take: assert property (
        @(posedge MCLK) disable iff (RST)
        (normal_take && ecer_code_legal(EXC.code)) |=>
        exception_cause_code == $past(EXC.code))
        else $error("exception code not recorded");

    a_apro_take: assert property (
        @(posedge MCLK) disable iff (RST)
        (normal_take && ecer_code_legal(EXC.code)) |=>
        autoprologue_exception_flag == $past(EXC.in_prologue))
        else $error("prologue flag not recorded");

    a_chain_flag: assert property (
        @(posedge MCLK) disable iff (RST)
        INTERRUPT_RETURN_INSTR_DONE |=> chained_return_flag == $past(INTERRUPT_RETURN_INSTR_CHAINED))
        else $error("chained return flag not loaded");

    a_vec_offset: assert property (
        @(posedge MCLK) disable iff (RST)
        1'b1 |=> VECTOR_OFFSET == ($past(interrupt_vector_select)
                                   ? VEC_SPECIAL : VEC_GENERAL))
        else $error("vector offset does not follow select bit");

    a_vec_base: assert property (
        @(posedge MCLK) disable iff (RST)
        (interrupt_vector_select && !BOOT_VEC) |=> VECTORED_BASE)
        else $error("vectored base not flagged");

    a_fdc_pending: assert property (
        @(posedge MCLK) disable iff (RST)
        1'b1 |=> debug_channel_irq_pending == $past(FDC_IRQ))
        else $error("debug channel pending bit does not track input");

    a_hw_pending: assert property (
        @(posedge MCLK) disable iff (RST)
        (!EIC_MODE && !TIMER_IRQ && !PERF_IRQ) |=>
        hw_pending_bits == $past(HW_IRQ[7:0]))
        else $error("pending bits do not track hardware inputs");

    a_irq_merge: assert property (
        @(posedge MCLK) disable iff (RST)
        (!EIC_MODE && (TIMER_IRQ || PERF_IRQ)) |=>
        hw_pending_bits[MERGE_IDX])
        else $error("timer or counter interrupt not merged");

    a_eic_level: assert property (
        @(posedge MCLK) disable iff (RST)
        EIC_MODE |=> hw_pending_bits == $past(EIC_LEVEL))
        else $error("requested level not shown");

    a_soft_write: assert property (
        @(posedge MCLK) disable iff (RST)
        cop_wr_cause |=>
        soft_irq_request_bits == $past(COP.wdata[CAUSE_SWI_LO +: 2]))
        else $error("software request bits not written");

    a_view_soft: assert property (
        @(posedge MCLK) disable iff (RST)
        (COP.wr && COP.sel == SEL_VIEW) |=>
        soft_irq_request_bits == $past(COP.wdata[1:0]))
        else $error("view write did not reach software bits");

    a_soft_out: assert property (
        @(posedge MCLK) disable iff (RST)
        cop_wr_cause |=> ##1 SOFT_IRQ_OUT ==
        $past(COP.wdata[CAUSE_SWI_LO +: 2], 2))
        else $error("software request output lags");

    a_sram_keeps: assert property (
        @(posedge MCLK) disable iff (RST)
        (EXC.take && EXC.kind == ECER_KIND_SRAM) |=>
        $stable(exception_cause_code))
        else $error("sram error changed cause");

    a_sram_debug: assert property (
        @(posedge MCLK) disable iff (RST)
        (EXC.take && EXC.kind == ECER_KIND_SRAM && DEBUG_MODE) |=>
        (DEBUG_SRAM_CODE_VALID && DEBUG_SRAM_CODE == EXC_SRAM))
        else $error("sram error in debug mode not reported");

    a_zero_bits: assert property (
        @(posedge MCLK) disable iff (RST)
        CAUSE_OUT[22] == 1'b0 && CAUSE_OUT[20:18] == 3'h0
        && CAUSE_OUT[7] == 1'b0 && CAUSE_OUT[1:0] == 2'h0)
        else $error("reserved cause bits not zero");

    a_snap_debug: assert property (
        @(posedge MCLK) disable iff (RST)
        (EXC.take && EXC.kind == ECER_KIND_DEBUG) |=>
        $stable(snap_erl) && $stable(snap_exl))
        else $error("debug exception changed snapshot");

    a_snap_erl: assert property (
        @(posedge MCLK) disable iff (RST)
        (EXC.take && EXC.kind != ECER_KIND_DEBUG) |=>
        snap_erl == $past(STATUS_ERL))
        else $error("saved error level wrong");

    a_snap_exl: assert property (
        @(posedge MCLK) disable iff (RST)
        normal_take |=> snap_exl == $past(STATUS_EXL))
        else $error("saved exception level wrong");

    a_snap_errpc: assert property (
        @(posedge MCLK) disable iff (RST)
        (EXC.take && EXC.kind != ECER_KIND_NORMAL) |=> $stable(snap_exl))
        else $error("saved exception level changed by wrong kind");

    a_epc_hold_exl: assert property (
        @(posedge MCLK) disable iff (RST)
        (EXC.take && STATUS_EXL && !COP.wr) |=> $stable(exception_return_pc))
        else $error("return pc changed while exception level set");

    a_epc_take: assert property (
        @(posedge MCLK) disable iff (RST)
        (normal_take && !STATUS_EXL && !COP.wr) |=>
        exception_return_pc == ($past(EXC.in_slot) ? $past(EXC.branch_pc)
                                   : $past(EXC.pc)))
        else $error("return pc not loaded on exception");

    a_epc_write: assert property (
        @(posedge MCLK) disable iff (RST)
        (COP.wr && COP.sel == SEL_EPC) |=>
        (exception_return_pc == {$past(COP.wdata[31:1]), 1'b0}
         && ISA_MODE == {1'b0, $past(COP.wdata[0])}))
        else $error("return pc write mapping wrong");

    a_epc_read: assert property (
        @(posedge MCLK) disable iff (RST)
        (COP.rd && COP.sel == SEL_EPC) |=>
        RDATA == {$past(exception_return_pc[31:1]), $past(ISA_MODE[0])})
        else $error("return pc read mapping wrong");

endmodule : ecer_regs

// *** tb/ecer_eic_model.sv ***
// far-side model: external interrupt controller priority encoder
`timescale 1ns/1ps
module ecer_eic_model (
    input  wire logic [1:0] soft_req,
    input  wire logic [7:0] src_level,
    output logic      [7:0] req_level
);
    // hardware sources outrank the two software requests
    always_comb begin
        if (src_level != 8'h00)
            req_level = src_level;
        else if (soft_req[1])
            req_level = 8'h02;
        else
            req_level = {7'h00, soft_req[0]};
    end
endmodule : ecer_eic_model

// *** tb/ecer_regs_tb.sv ***
// self-checking bench for the exception cause and return pc registers
`timescale 1ns/1ps
module exception_cause_epc_registers_tb_top;
    import ecer_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    ecer_exc_t   exc_r = '0;
    ecer_cop_t   cop_r = '0;
    logic        interrupt_return_instr_done = 1'b0, interrupt_return_instr_chained = 1'b0, eic_mode = 1'b0;
    logic        boot_vec = 1'b0, fdc_irq = 1'b0, debug_mode = 1'b0;
    logic        timer_irq = 1'b0, perf_irq = 1'b0;
    logic        st_exl = 1'b0, st_erl = 1'b0;
    logic [7:0]  hw_irq = 8'h00, src_level = 8'h00, eic_level;
    logic [31:0] rdata, vec_off, cause_out;
    logic [1:0]  soft_out, isa_mode;
    logic        vec_base, br_slot, dbg_v, seen_v;
    logic [4:0]  dbg_c;
    int          n_mismatch = 0, cmp_count = 0, cycles = 0;
    logic [4:0]  codes[16] = '{EXC_INT, EXC_ADEL, EXC_ADES, EXC_IBE,
        EXC_DBE, EXC_SYS, EXC_BP, EXC_RI, EXC_CPU, EXC_OV, EXC_TR,
        EXC_IS1, EXC_CEU, EXC_C2E, EXC_DSPD, EXC_PROT};
    logic [4:0]  rsv[4] = '{5'h01, 5'h13, 5'h1b, 5'h1f};

    ecer_regs i_dut (.MCLK(mclk), .RST(rst), .EXC(exc_r), .COP(cop_r),
        .INTERRUPT_RETURN_INSTR_DONE(interrupt_return_instr_done), .INTERRUPT_RETURN_INSTR_CHAINED(interrupt_return_instr_chained),
        .EIC_MODE(eic_mode), .HW_IRQ(hw_irq), .TIMER_IRQ(timer_irq),
        .PERF_IRQ(perf_irq), .FDC_IRQ(fdc_irq), .EIC_LEVEL(eic_level),
        .BOOT_VEC(boot_vec), .STATUS_EXL(st_exl), .STATUS_ERL(st_erl),
        .DEBUG_MODE(debug_mode), .RDATA(rdata), .SOFT_IRQ_OUT(soft_out),
        .VECTOR_OFFSET(vec_off), .VECTORED_BASE(vec_base),
        .CAUSE_OUT(cause_out), .BRANCH_SLOT(br_slot), .ISA_MODE(isa_mode),
        .DEBUG_SRAM_CODE_VALID(dbg_v), .DEBUG_SRAM_CODE(dbg_c));

    ecer_eic_model i_eic (.soft_req(soft_out), .src_level(src_level),
        .req_level(eic_level));

    initial begin
        forever #10 mclk = ~mclk;
    end

    task automatic results();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [1:0] sel, input logic [31:0] d);
        @(posedge mclk);
        cop_r <= '{wr: 1'b1, rd: 1'b0, sel: sel, wdata: d};
        @(posedge mclk);
        cop_r.wr <= 1'b0;
    endtask : wr

    // read is taken at one edge, data settles just after it
    task automatic rchk(input logic [1:0] sel, input logic [31:0] exp,
                        input string what);
        @(posedge mclk);
        cop_r.rd <= 1'b1;
        cop_r.sel <= sel;
        @(posedge mclk);
        cop_r.rd <= 1'b0;
        #1 chk(what, exp, rdata);
    endtask : rchk

    task automatic ex(input ecer_kind_t k, input logic [4:0] c,
                      input logic [31:0] pc, input logic slot, pro,
                      input logic exception_level_flag, error_level_flag);
        @(posedge mclk);
        exc_r <= '{take: 1'b1, kind: k, code: c, pc: pc,
                   branch_pc: 32'h0000_4000, in_slot: slot,
                   in_prologue: pro};
        st_exl <= exception_level_flag;
        st_erl <= error_level_flag;
        @(posedge mclk);
        exc_r.take <= 1'b0;
        #1 seen_v = dbg_v;
    endtask : ex

    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rchk(SEL_CAUSE, 32'h0000_0000, "cause reset");
        chk("vector reset", VEC_GENERAL, vec_off);
        wr(SEL_CAUSE, 32'h03a3_ff7c);
        rchk(SEL_CAUSE, 32'h0080_0300, "cause writable");
        chk("soft out", 32'h0000_0003, {30'h0, soft_out});
        chk("vector special", VEC_SPECIAL, vec_off);
        chk("vectored base", 32'h0000_0001, {31'h0, vec_base});
        @(posedge mclk) boot_vec <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk("vectored boot", 32'h0000_0000, {31'h0, vec_base});
        wr(SEL_VIEW, 32'h0000_03fc);
        rchk(SEL_VIEW, 32'h0000_0000, "view soft clear");
        @(posedge mclk);
        hw_irq <= 8'h81;
        fdc_irq <= 1'b1;
        rchk(SEL_CAUSE, 32'h00a2_0400, "cause pending");
        rchk(SEL_VIEW, 32'h0000_0204, "view pending");
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk);
            hw_irq <= 8'h00;
            fdc_irq <= 1'b0;
            {timer_irq, perf_irq} <= (i == 0) ? 2'b10 : 2'b01;
            rchk(SEL_CAUSE, 32'h0080_8000, "merged irq");
        end
        @(posedge mclk);
        perf_irq <= 1'b0;
        eic_mode <= 1'b1;
        wr(SEL_VIEW, 32'h0000_0002);
        @(posedge mclk);
        rchk(SEL_CAUSE, 32'h0080_0a00, "level soft");
        @(posedge mclk) src_level <= 8'hff;
        rchk(SEL_VIEW, 32'h0000_03fe, "view level");
        @(posedge mclk);
        eic_mode <= 1'b0;
        src_level <= 8'h00;
        wr(SEL_VIEW, 32'h0000_0000);
        foreach (codes[i]) begin
            ex(ECER_KIND_NORMAL, codes[i], 32'h0, 1'b0, 1'b0, 1'b1, 1'b0);
            rchk(SEL_CAUSE, {25'h001_0000, codes[i], 2'b00},
                 "code");
        end
        foreach (rsv[i]) begin
            ex(ECER_KIND_NORMAL, rsv[i], 32'h0, 1'b0, 1'b0, 1'b1, 1'b0);
            rchk(SEL_CAUSE, 32'h0080_0074, "reserved code");
        end
        ex(ECER_KIND_SRAM, EXC_INT, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("sram normal", 32'h0000_0000, {31'h0, seen_v});
        rchk(SEL_CAUSE, 32'h0080_0074, "sram cause");
        @(posedge mclk) debug_mode <= 1'b1;
        ex(ECER_KIND_SRAM, EXC_INT, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("sram debug", 32'h0000_0001, {31'h0, seen_v});
        chk("sram code", 32'h0000_001e, {27'h0, dbg_c});
        @(posedge mclk) debug_mode <= 1'b0;
        ex(ECER_KIND_NORMAL, EXC_SYS, 32'h0000_1234, 1'b0, 1'b0, 1'b0, 1'b0);
        rchk(SEL_EPC, 32'h0000_1234, "epc fault");
        rchk(SEL_SNAP, 32'h0000_0000, "snap clear");
        ex(ECER_KIND_NORMAL, EXC_OV, 32'h0000_2000, 1'b1, 1'b0, 1'b0, 1'b0);
        rchk(SEL_EPC, 32'h0000_4000, "epc branch");
        chk("slot flag", 32'h0000_0001, {31'h0, br_slot});
        ex(ECER_KIND_NORMAL, EXC_OV, 32'h0000_3000, 1'b0, 1'b0, 1'b1, 1'b1);
        rchk(SEL_EPC, 32'h0000_4000, "epc held");
        rchk(SEL_SNAP, 32'h0000_0006, "snap levels");
        ex(ECER_KIND_DEBUG, EXC_INT, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0);
        rchk(SEL_SNAP, 32'h0000_0006, "snap debug");
        ex(ECER_KIND_ERROR, EXC_INT, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0);
        rchk(SEL_SNAP, 32'h0000_0002, "snap error");
        wr(SEL_SNAP, 32'hffff_ffff);
        rchk(SEL_SNAP, 32'h0000_0002, "snap write");
        wr(SEL_EPC, 32'h0000_1001);
        rchk(SEL_EPC, 32'h0000_1001, "epc write");
        chk("isa mode", 32'h0000_0001, {30'h0, isa_mode});
        @(posedge mclk);
        interrupt_return_instr_done <= 1'b1;
        interrupt_return_instr_chained <= 1'b1;
        @(posedge mclk) interrupt_return_instr_done <= 1'b0;
        ex(ECER_KIND_NORMAL, EXC_BP, 32'h0, 1'b0, 1'b1, 1'b1, 1'b0);
        rchk(SEL_CAUSE, 32'h0380_0024, "chain prologue");
        chk("cause out", 32'h0380_0024, cause_out);
        results();
    end
endmodule : exception_cause_epc_registers_tb_top
